// file: rtl/flash_ctl_map.svh
`ifndef FLASH_CTL_MAP_SVH
`define FLASH_CTL_MAP_SVH

// Register bus geometry
`define ADDR_W 8
`define DATA_W 8

// Register offsets
`define CTL_ONE_ADDR 8'h00
`define STATUS_TWO_ADDR 8'h01
`define INT_STATUS_ADDR 8'h02
`define INT_CLEAR_ADDR 8'h03
`define INT_ENABLE_ADDR 8'h04
`define REFUSE_CNT_ADDR 8'h05
`define MODE_STATE_ADDR 8'h06

// Control register one fields
`define CTL_HW_WE_BIT 7
`define CTL_SWE_BIT 6
`define CTL_ESU_BIT 5
`define CTL_PSU_BIT 4
`define CTL_PV_BIT 2
`define CTL_ER_BIT 1
`define CTL_PG_BIT 0

// Status register two fields
`define STAT_ERR_BIT 7

// Interrupt events
`define EVT_W 3
`define EVT_ERROR_BIT 0
`define EVT_REFUSE_BIT 1
`define EVT_HW_DROP_BIT 2

// Reset values and refusal counter limit
`define DATA_RESET 8'h00
`define EVT_RESET 3'h0
`define REFUSE_CNT_MAX 8'hFF

`endif

// file: rtl/flash_ctl_pkg.sv
`include "flash_ctl_map.svh"

package flash_ctl_pkg;

  typedef enum logic [2:0] {
    MODE_IDLE    = 3'b000,
    MODE_VERIFY  = 3'b001,
    MODE_ERASE   = 3'b010,
    MODE_PROGRAM = 3'b011,
    MODE_ERROR   = 3'b100
  } mode_t;

  typedef struct packed {
    logic hw_we;
    logic swe;
    logic esu;
    logic psu;
    logic pv;
    logic er;
    logic pg;
    logic err;
    mode_t mode;
    logic [`DATA_W-1:0] refuse_cnt;
    logic [`DATA_W-1:0] rd_data;
    logic program_mode;
    logic erase_mode;
    logic verify_mode;
    logic error_protect;
  } ctl_state_t;

  typedef struct packed {
    logic [`EVT_W-1:0] status;
    logic [`EVT_W-1:0] enable;
    logic irq;
  } irq_state_t;

endpackage

// file: rtl/flash_irq_block.sv
`timescale 1ns/1ps
`include "flash_ctl_map.svh"

module flash_irq_block (
  input wire logic ref_clk, // System clock
  input wire logic rstn, // Synchronous reset, low
  input wire logic [`EVT_W-1:0] event_set, // One-cycle event pulses
  input wire logic clear_wr, // Write to clear register
  input wire logic enable_wr, // Write to enable register
  input wire logic [`EVT_W-1:0] wr_bits, // Write data bits
  output logic [`EVT_W-1:0] status, // Sticky status
  output logic [`EVT_W-1:0] enable, // Enable mask
  output logic irq // Level interrupt
);

  flash_ctl_pkg::irq_state_t s_q;
  flash_ctl_pkg::irq_state_t s_d;

  always_comb begin
    s_d = s_q;
    if (clear_wr) begin
      s_d.status = s_q.status & ~wr_bits;
    end
    // Set wins over a clear in the same cycle
    s_d.status = s_d.status | event_set;
    if (enable_wr) begin
      s_d.enable = wr_bits;
    end
    s_d.irq = |(s_d.status & s_d.enable);
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign status = s_q.status;
  assign enable = s_q.enable;
  assign irq = s_q.irq;

endmodule

// file: rtl/flash_program_erase_control.sv
// Overview of operation
// - Program-verify bit one enters verify mode; zero leaves it.
// - Program-verify set accepted only with hardware protect state and software enable.
// - Erase bit set needs hardware state, software enable and erase setup.
// - Program bit set needs hardware state, software enable and program setup.
// - Writing zero to erase or program bit cancels that mode.
// - Hardware protect state bit is read-only and follows the input pin.
// - Inactive protect input blocks and cancels programming and erasing.
// - Failed program or erase sets error flag; flash then stays error-protected.
// - Low seven bits of status register two always read zero.
// - Mask-ROM variant has no such registers; writes ignored, reads meaningless.
`timescale 1ns/1ps
`include "flash_ctl_map.svh"

module flash_program_erase_control #(
  parameter bit MASK_ROM_VARIANT = 1'b0 // Flash control absent when set
) (
  input wire logic ref_clk, // System clock, 100 MHz
  input wire logic rstn, // Synchronous reset, low
  input wire logic [`ADDR_W-1:0] addr, // Register address
  input wire logic [`DATA_W-1:0] wr_data, // Write data
  input wire logic wr_stb, // Write strobe
  input wire logic rd_stb, // Read strobe
  input wire logic hw_write_protect_input, // Protection pin, high allows
  input wire logic op_fail, // Array reports failed operation
  output logic [`DATA_W-1:0] rd_data, // Read data, cycle after strobe
  output logic program_mode, // Array in program mode
  output logic erase_mode, // Array in erase mode
  output logic verify_mode, // Array in program-verify mode
  output logic error_protect, // Array in error protection
  output logic irq // Level interrupt
);

  flash_ctl_pkg::ctl_state_t s_q;
  flash_ctl_pkg::ctl_state_t s_d;

  logic [`EVT_W-1:0] evt;
  logic [`EVT_W-1:0] int_status;
  logic [`EVT_W-1:0] int_enable;
  logic irq_raw;
  logic ctl_wr;
  logic clear_wr;
  logic enable_wr;

  // Address match, gated off entirely in the mask-ROM build
  function automatic logic hit(input logic [`ADDR_W-1:0] a, input logic [`ADDR_W-1:0] target);
    hit = (a == target);
  endfunction

  function automatic flash_ctl_pkg::mode_t mode_of(
    input logic err,
    input logic er,
    input logic pg,
    input logic pv
  );
    if (err) begin
      mode_of = flash_ctl_pkg::MODE_ERROR;
    end else if (er) begin
      mode_of = flash_ctl_pkg::MODE_ERASE;
    end else if (pg) begin
      mode_of = flash_ctl_pkg::MODE_PROGRAM;
    end else if (pv) begin
      mode_of = flash_ctl_pkg::MODE_VERIFY;
    end else begin
      mode_of = flash_ctl_pkg::MODE_IDLE;
    end
  endfunction

  function automatic logic [`DATA_W-1:0] ctl_image(input flash_ctl_pkg::ctl_state_t s);
    logic [`DATA_W-1:0] v;
    v = `DATA_RESET;
    v[`CTL_HW_WE_BIT] = s.hw_we;
    v[`CTL_SWE_BIT] = s.swe;
    v[`CTL_ESU_BIT] = s.esu;
    v[`CTL_PSU_BIT] = s.psu;
    v[`CTL_PV_BIT] = s.pv;
    v[`CTL_ER_BIT] = s.er;
    v[`CTL_PG_BIT] = s.pg;
    ctl_image = v;
  endfunction

  // Register write decode
  always_comb begin
    ctl_wr = 1'b0;
    clear_wr = 1'b0;
    enable_wr = 1'b0;
    // Absent registers swallow writes
    if (wr_stb && !MASK_ROM_VARIANT) begin
      ctl_wr = hit(addr, `CTL_ONE_ADDR);
      clear_wr = hit(addr, `INT_CLEAR_ADDR);
      enable_wr = hit(addr, `INT_ENABLE_ADDR);
    end
  end

  // Main control next state
  always_comb begin
    logic want_pv;
    logic want_er;
    logic want_pg;
    logic allow_base;
    logic refused;
    logic fail_hit;
    logic hw_drop;
    want_pv = 1'b0;
    want_er = 1'b0;
    want_pg = 1'b0;
    allow_base = 1'b0;
    refused = 1'b0;
    fail_hit = 1'b0;
    hw_drop = 1'b0;
    s_d = s_q;
    evt = `EVT_RESET;

    s_d.hw_we = hw_write_protect_input;
    hw_drop = s_q.hw_we && !hw_write_protect_input;

    // Gate on current pin state so a write in the drop cycle is refused
    allow_base = hw_write_protect_input && s_q.swe && !s_q.err;

    if (ctl_wr) begin
      want_pv = wr_data[`CTL_PV_BIT];
      want_er = wr_data[`CTL_ER_BIT];
      want_pg = wr_data[`CTL_PG_BIT];

      // Software enable only latches while the pin allows it
      s_d.swe = wr_data[`CTL_SWE_BIT] && hw_write_protect_input;
      s_d.esu = wr_data[`CTL_ESU_BIT] && s_d.swe;
      s_d.psu = wr_data[`CTL_PSU_BIT] && s_d.swe;

      if (!want_pv) begin
        s_d.pv = 1'b0;
      end else if (s_q.pv) begin
        s_d.pv = 1'b1;
      end else begin
        s_d.pv = allow_base;
        refused = refused | !allow_base;
      end

      if (!want_er) begin
        s_d.er = 1'b0;
      end else if (s_q.er) begin
        s_d.er = 1'b1;
      end else begin
        s_d.er = allow_base && s_q.esu && !s_q.pg && !want_pg;
        refused = refused | !s_d.er;
      end

      if (!want_pg) begin
        s_d.pg = 1'b0;
      end else if (s_q.pg) begin
        s_d.pg = 1'b1;
      end else begin
        s_d.pg = allow_base && s_q.psu && !s_q.er && !want_er;
        refused = refused | !s_d.pg;
      end
    end

    fail_hit = op_fail && (s_q.er || s_q.pg) && !s_q.err;
    if (fail_hit) begin
      s_d.err = 1'b1;
    end

    if (s_d.err) begin
      s_d.pv = 1'b0;
      s_d.er = 1'b0;
      s_d.pg = 1'b0;
    end

    if (!hw_write_protect_input) begin
      s_d.swe = 1'b0;
      s_d.esu = 1'b0;
      s_d.psu = 1'b0;
      s_d.pv = 1'b0;
      s_d.er = 1'b0;
      s_d.pg = 1'b0;
    end

    // Saturating so a runaway loop cannot wrap to zero
    if (refused && s_q.refuse_cnt != `REFUSE_CNT_MAX) begin
      s_d.refuse_cnt = s_q.refuse_cnt + 8'h01;
    end

    evt[`EVT_ERROR_BIT] = fail_hit;
    evt[`EVT_REFUSE_BIT] = refused;
    evt[`EVT_HW_DROP_BIT] = hw_drop;

    s_d.mode = mode_of(s_d.err, s_d.er, s_d.pg, s_d.pv);
    s_d.program_mode = (s_d.mode == flash_ctl_pkg::MODE_PROGRAM);
    s_d.erase_mode = (s_d.mode == flash_ctl_pkg::MODE_ERASE);
    s_d.verify_mode = s_d.pv;
    s_d.error_protect = (s_d.mode == flash_ctl_pkg::MODE_ERROR);

    // Read data stands only in the cycle after the strobe
    s_d.rd_data = `DATA_RESET;
    // absent registers read as zero here
    if (rd_stb && !MASK_ROM_VARIANT) begin
      if (hit(addr, `CTL_ONE_ADDR)) begin
        s_d.rd_data = ctl_image(s_q);
      end else if (hit(addr, `STATUS_TWO_ADDR)) begin
        s_d.rd_data = `DATA_RESET;
        s_d.rd_data[`STAT_ERR_BIT] = s_q.err;
      end else if (hit(addr, `INT_STATUS_ADDR)) begin
        s_d.rd_data = {{(`DATA_W-`EVT_W){1'b0}}, int_status};
      end else if (hit(addr, `INT_ENABLE_ADDR)) begin
        s_d.rd_data = {{(`DATA_W-`EVT_W){1'b0}}, int_enable};
      end else if (hit(addr, `REFUSE_CNT_ADDR)) begin
        s_d.rd_data = s_q.refuse_cnt;
      end else if (hit(addr, `MODE_STATE_ADDR)) begin
        s_d.rd_data = {5'h00, s_q.mode};
      end else begin
        s_d.rd_data = `DATA_RESET;
      end
    end
    // writes to status two have no effect
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  flash_irq_block u_irq (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .event_set(evt),
    .clear_wr(clear_wr),
    .enable_wr(enable_wr),
    .wr_bits(wr_data[`EVT_W-1:0]),
    .status(int_status),
    .enable(int_enable),
    .irq(irq_raw)
  );

  assign rd_data = s_q.rd_data;
  assign program_mode = s_q.program_mode;
  assign erase_mode = s_q.erase_mode;
  assign verify_mode = s_q.verify_mode;
  assign error_protect = s_q.error_protect;
  assign irq = irq_raw;

endmodule

// file: sim/flash_ctl_sva.sv
`timescale 1ns/1ps
`include "flash_ctl_map.svh"
module flash_ctl_sva (
  input wire logic ref_clk, // Clock
  input wire logic rstn, // Reset, low
  input wire logic [`ADDR_W-1:0] addr, // Address
  input wire logic [`DATA_W-1:0] wr_data, // Write data
  input wire logic wr_stb, // Write strobe
  input wire logic rd_stb, // Read strobe
  input wire logic hw_write_protect_input, // Pin
  input wire logic op_fail, // Failure
  input wire logic [`DATA_W-1:0] rd_data, // Read data
  input wire logic program_mode, // Program
  input wire logic erase_mode, // Erase
  input wire logic verify_mode, // Verify
  input wire logic error_protect, // Error
  input wire logic irq // Interrupt
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  logic cw;
  assign cw = wr_stb && addr == `CTL_ONE_ADDR;
  verify_gate_a: assert property ($rose(verify_mode) |-> $past(cw && wr_data[`CTL_PV_BIT] && hw_write_protect_input))
    else $error("verify entered without gated write");
  erase_gate_a: assert property ($rose(erase_mode) |-> $past(cw && wr_data[`CTL_ER_BIT] && hw_write_protect_input))
    else $error("erase entered without gated write");
  program_gate_a: assert property ($rose(program_mode) |-> $past(cw && wr_data[`CTL_PG_BIT] && hw_write_protect_input))
    else $error("program entered without gated write");
  verify_clear_a: assert property (cw && !wr_data[`CTL_PV_BIT] |=> !verify_mode)
    else $error("verify not left");
  erase_cancel_a: assert property (cw && !wr_data[`CTL_ER_BIT] |=> !erase_mode)
    else $error("erase not cancelled");
  program_cancel_a: assert property (cw && !wr_data[`CTL_PG_BIT] |=> !program_mode)
    else $error("program not cancelled");
  status_low_a: assert property (rd_stb && addr == `STATUS_TWO_ADDR |=> rd_data[6:0] == 7'h00)
    else $error("status low bits not zero");
  error_sticky_a: assert property (error_protect |=> error_protect)
    else $error("error flag dropped");
  error_blocks_a: assert property (error_protect && $past(error_protect) |-> !(program_mode || erase_mode || verify_mode))
    else $error("mode active in error state");
  pin_blocks_a: assert property (!hw_write_protect_input [*2] |=> !program_mode && !erase_mode)
    else $error("mode active with pin low");
  modes_exclusive_a: assert property (!(program_mode && erase_mode))
    else $error("program and erase together");
  cover property ($rose(program_mode));
  cover property ($rose(erase_mode));
  cover property ($rose(error_protect));
  cover property ($rose(irq));
endmodule
bind flash_program_erase_control flash_ctl_sva u_sva (.ref_clk, .rstn, .addr, .wr_data, .wr_stb, .rd_stb,
  .hw_write_protect_input, .op_fail, .rd_data, .program_mode, .erase_mode, .verify_mode, .error_protect, .irq);

// file: sim/flash_program_erase_control_tb_top.sv
`timescale 1ns/1ps
`include "flash_ctl_map.svh"
module flash_program_erase_control_tb_top;
  localparam logic [7:0] CTL = `CTL_ONE_ADDR;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wr_data = 8'h00;
  logic wr_stb = 1'b0;
  logic rd_stb = 1'b0;
  logic pin = 1'b1;
  logic op_fail = 1'b0;
  logic [7:0] rd_data;
  logic program_mode, erase_mode, verify_mode, error_protect, irq;
  logic [7:0] rom_rd_data;
  logic rom_program_mode, rom_erase_mode, rom_verify_mode, rom_error_protect, rom_irq;
  logic [31:0] seed = 32'h36C3;
  int err_total = 0;
  int checked = 0;
  int refusals = 0;
  always #5 ref_clk = ~ref_clk;
  flash_program_erase_control dut (.ref_clk, .rstn, .addr, .wr_data, .wr_stb, .rd_stb,
    .hw_write_protect_input(pin), .op_fail, .rd_data, .program_mode, .erase_mode, .verify_mode,
    .error_protect, .irq);
  // Mask-ROM build sees the same traffic and must ignore all of it
  flash_program_erase_control #(.MASK_ROM_VARIANT(1'b1)) dut_rom (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .addr(addr),
    .wr_data(wr_data),
    .wr_stb(wr_stb),
    .rd_stb(rd_stb),
    .hw_write_protect_input(pin),
    .op_fail(op_fail),
    .rd_data(rom_rd_data),
    .program_mode(rom_program_mode),
    .erase_mode(rom_erase_mode),
    .verify_mode(rom_verify_mode),
    .error_protect(rom_error_protect),
    .irq(rom_irq)
  );
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    wr_stb <= 1'b1;
    addr <= a;
    wr_data <= d;
    @(posedge ref_clk);
    wr_stb <= 1'b0;
  endtask
  // Read data lives one cycle only, so sample mid-cycle
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    rd_stb <= 1'b1;
    addr <= a;
    @(posedge ref_clk);
    rd_stb <= 1'b0;
    @(negedge ref_clk);
    chk(rd_data, e);
    chk(rom_rd_data, 8'h00);
  endtask
  task automatic modes(input logic [3:0] e);
    repeat (2) @(negedge ref_clk);
    chk({4'h0, program_mode, erase_mode, verify_mode, error_protect}, {4'h0, e});
    chk({3'h0, rom_program_mode, rom_erase_mode, rom_verify_mode, rom_error_protect, rom_irq}, 8'h00);
  endtask
  task automatic irq_is(input logic e);
    repeat (3) @(negedge ref_clk);
    chk({7'h00, irq}, {7'h00, e});
  endtask
  task automatic finish_test();
    $display("checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge ref_clk);
    err_total++;
    finish_test();
  end
  initial begin
    repeat (12) @(posedge ref_clk);
    rstn <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rd(CTL, 8'h80);
    wr(CTL, 8'h04);
    refusals++;
    modes(4'h0);
    wr(CTL, 8'h40);
    wr(CTL, 8'h44);
    modes(4'h2);
    rd(CTL, 8'hC4);
    wr(CTL, 8'h40);
    modes(4'h0);
    wr(CTL, 8'h42);
    refusals++;
    modes(4'h0);
    wr(CTL, 8'h60);
    wr(CTL, 8'h62);
    modes(4'h4);
    wr(CTL, 8'h60);
    modes(4'h0);
    wr(CTL, 8'h50);
    wr(CTL, 8'h51);
    modes(4'h8);
    wr(CTL, 8'h50);
    modes(4'h0);
    rd(`REFUSE_CNT_ADDR, refusals[7:0]);
    wr(`INT_ENABLE_ADDR, 8'h02);
    irq_is(1'b1);
    wr(`INT_CLEAR_ADDR, 8'h02);
    irq_is(1'b0);
    wr(`INT_ENABLE_ADDR, 8'h04);
    wr(CTL, 8'h51);
    @(posedge ref_clk);
    pin <= 1'b0;
    modes(4'h0);
    irq_is(1'b1);
    rd(CTL, 8'h00);
    wr(CTL, 8'h40);
    rd(CTL, 8'h00);
    @(posedge ref_clk);
    pin <= 1'b1;
    wr(`INT_CLEAR_ADDR, 8'h07);
    wr(`INT_ENABLE_ADDR, 8'h01);
    wr(CTL, 8'h50);
    wr(CTL, 8'h51);
    @(posedge ref_clk);
    op_fail <= 1'b1;
    @(posedge ref_clk);
    op_fail <= 1'b0;
    modes(4'h1);
    irq_is(1'b1);
    rd(`STATUS_TWO_ADDR, 8'h80);
    wr(CTL, 8'h44);
    modes(4'h1);
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      wr(`STATUS_TWO_ADDR, seed[7:0]);
      rd(`STATUS_TWO_ADDR, 8'h80);
      wr(`INT_ENABLE_ADDR, seed[15:8]);
      rd(`INT_ENABLE_ADDR, {5'h00, seed[10:8]});
      rd({4'h2, seed[19:16]}, 8'h00);
    end
    finish_test();
  end
endmodule
